// ### logic/scmd_pkg.sv
// Purpose: Shared constants and types of the slot command block.
// Assumes: 125 MHz mclk.
// Notes:   Register offsets are byte addresses on the plain port.
package scmd_pkg;
	localparam int          CLK_MHZ      = 125;
	localparam int          UPD_MS       = 58;
	localparam int          UPD_CYC      = UPD_MS * CLK_MHZ * 1000;
	localparam int          LED_STEP_MS  = 125;
	localparam int          LED_STEP_CYC = LED_STEP_MS * CLK_MHZ * 1000;
	localparam int          NSLOT        = 4;
	localparam logic [3:0]  ROT_MAX      = 4'h9;
	localparam logic [7:0]  A_CFG        = 8'h00;
	localparam logic [7:0]  A_TICK       = 8'h04;
	localparam logic [7:0]  A_DMASK      = 8'h08;
	localparam logic [7:0]  A_STAT       = 8'h0C;
	localparam logic [3:0]  A_ROT_HI     = 4'h1;
	localparam logic [7:0]  A_LED        = 8'h20;
	localparam int          CFG_FMT_LSB  = 0;
	localparam int          CFG_ORD_LSB  = 2;
	localparam int          CFG_NSL_LSB  = 4;
	localparam logic [1:0]  FMT_RST      = 2'h0;
	localparam logic [1:0]  ORD_RST      = 2'h2;
	localparam logic [1:0]  NSL_RST      = 2'h0;
	localparam logic [3:0]  DMASK_RST    = 4'h0;
	localparam logic [15:0] OP_NEXT1     = 16'h0001;
	localparam logic [15:0] OP_NEXT2     = 16'h0002;
	localparam logic [15:0] OP_AUTO      = 16'h0003;
	localparam logic [15:0] OP_CLR       = 16'h0004;
	localparam logic [11:0] OP_ADD       = 12'h001;
	localparam logic [11:0] OP_RPT       = 12'h002;
	localparam logic [11:0] OP_LDT       = 12'h003;
	localparam int          RSP_INTEG    = 15;
	localparam int          RSP_IND_LSB  = 10;
	localparam int          RSP_ACK_LSB  = 8;
	localparam int          STAT_INTEG   = 15;
	localparam logic [15:0] INT_MAX      = 16'h7FFF;

	typedef enum logic [1:0] {FMT_INT, FMT_DIV, FMT_FLT, FMT_APP} scmd_fmt_t;
	typedef enum logic [1:0] {ORD_STD, ORD_BYTE, ORD_WORD, ORD_DWORD} scmd_ord_t;
	typedef enum logic [1:0] {Q_GROSS, Q_NET, Q_TARE, Q_TARGET} scmd_qty_t;
	typedef enum logic [2:0] {M_IDLE, M_RT, M_STAT, M_AUTO, M_MAN} scmd_mode_t;

	typedef struct packed {
		logic [15:0] cmd;
		logic [31:0] val;
	} scmd_cmd_t;

	typedef struct packed {
		logic [15:0] resp;
		logic [15:0] val_hi;
		logic [15:0] val_lo;
		logic [15:0] stat;
	} scmd_resp_t;
endpackage : scmd_pkg

// ### logic/scmd_slot_cmd.sv
// Purpose: PLC message slot command interpreter of a weighing terminal.
// Assumes: PLC words and scale values synchronous to mclk.
// Notes:   Slot commands and values advance on the interface update tick; a format change erases slot state at once.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/10ps

module scmd_slot_cmd #(
	parameter int UPD_CYC      = scmd_pkg::UPD_CYC,
	parameter int LED_STEP_CYC = scmd_pkg::LED_STEP_CYC
) (
	input  logic                          mclk,
	input  logic                          rst_b,
	input  logic                          ce,
	input  logic [7:0]                    reg_addr,
	input  logic [31:0]                   reg_wdata,
	input  logic                          reg_wr,
	input  logic                          reg_rd,
	output logic [31:0]                   reg_rdata,
	input  scmd_pkg::scmd_cmd_t [3:0]     plc_out,
	output scmd_pkg::scmd_resp_t [3:0]    plc_in,
	input  logic [31:0]                   gross_f,
	input  logic [31:0]                   net_f,
	input  logic [31:0]                   tare_f,
	input  logic [31:0]                   wt_int,
	input  logic [31:0]                   wt_div,
	input  logic [3:0]                    plc_dout,
	input  logic [3:0]                    disc_in,
	output logic [3:0]                    disc_out,
	input  logic [2:0]                    net_conn,
	input  logic                          pkt_evt,
	output logic                          led_mod_red,
	output logic                          led_net,
	output logic                          led_act
);
	logic [1:0]             fmt_reg, ord_reg, nsl_reg;
	logic [31:0]            per_reg, cnt_reg;
	logic                   tick_reg, tick_d_reg;
	logic [3:0]             dmask_reg, disc_in_reg, disc_out_reg, led_err_reg;
	logic [31:0]            rdata_reg, target_reg;
	logic [15:0]            last_reg [4];
	logic [1:0]             ack_reg  [4];
	scmd_pkg::scmd_qty_t    ind_reg  [4];
	scmd_pkg::scmd_mode_t   mode_reg [4];
	logic [31:0]            val_reg  [4];
	logic [3:0]             pos_reg  [4];
	logic [3:0]             rot_len_reg [4];
	logic [1:0]             rot_reg  [4][9];
	logic [3:0]             integ_reg;
	scmd_pkg::scmd_resp_t [3:0] plc_in_reg;
	logic [31:0]            step_cnt_reg;
	logic [2:0]             blink_reg;
	logic [4:0]             nph_reg;
	logic                   red_reg, net_reg, act_reg;
	logic [3:0]             acc;
	logic                   erase, step;

	function automatic logic [31:0] ord32(input logic [31:0] v, input logic [1:0] o);
		case (scmd_pkg::scmd_ord_t'(o))
			scmd_pkg::ORD_STD:  ord32 = v;
			scmd_pkg::ORD_BYTE: ord32 = {v[23:16], v[31:24], v[7:0], v[15:8]};
			scmd_pkg::ORD_WORD: ord32 = {v[15:0], v[31:16]};
			default:            ord32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
		endcase
	endfunction : ord32

	function automatic logic [15:0] sat16(input logic [31:0] x);
		if ($signed(x) > $signed({16'h0000, scmd_pkg::INT_MAX}))
			sat16 = scmd_pkg::INT_MAX;
		else if ($signed(x) < -$signed({16'h0000, scmd_pkg::INT_MAX}))
			sat16 = 16'h0000 - scmd_pkg::INT_MAX;
		else
			sat16 = x[15:0];
	endfunction : sat16

	function automatic logic is_rt(input logic [1:0] q);
		is_rt = (q == scmd_pkg::Q_GROSS) || (q == scmd_pkg::Q_NET);
	endfunction : is_rt

	function automatic logic [31:0] qval(input logic [1:0] q);
		case (scmd_pkg::scmd_qty_t'(q))
			scmd_pkg::Q_GROSS: qval = gross_f;
			scmd_pkg::Q_NET:   qval = net_f;
			scmd_pkg::Q_TARE:  qval = tare_f;
			default:           qval = target_reg;
		endcase
	endfunction : qval

	// Register writes and format-change erase
	assign erase = ce && reg_wr && reg_addr == scmd_pkg::A_CFG &&
	               reg_wdata[scmd_pkg::CFG_FMT_LSB +: 2] != fmt_reg;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fmt_reg     <= scmd_pkg::FMT_RST;
			ord_reg     <= scmd_pkg::ORD_RST;
			nsl_reg     <= scmd_pkg::NSL_RST;
			per_reg     <= 32'(UPD_CYC);
			dmask_reg   <= scmd_pkg::DMASK_RST;
			led_err_reg <= 4'h0;
		end else if (ce && reg_wr) begin
			case (reg_addr)
				scmd_pkg::A_CFG: begin
					fmt_reg <= reg_wdata[scmd_pkg::CFG_FMT_LSB +: 2];
					ord_reg <= reg_wdata[scmd_pkg::CFG_ORD_LSB +: 2];
					nsl_reg <= erase ? scmd_pkg::NSL_RST
					                 : reg_wdata[scmd_pkg::CFG_NSL_LSB +: 2];
				end
				scmd_pkg::A_TICK:  per_reg     <= (reg_wdata == 32'h0) ? 32'h1 : reg_wdata;
				scmd_pkg::A_DMASK: dmask_reg   <= reg_wdata[3:0];
				scmd_pkg::A_LED:   led_err_reg <= reg_wdata[3:0];
				default: ;
			endcase
		end
	end

	// Interface update tick
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg    <= 32'h0;
			tick_reg   <= 1'b0;
			tick_d_reg <= 1'b0;
		end else if (ce) begin
			tick_d_reg <= tick_reg;
			if (cnt_reg >= per_reg - 32'h1) begin
				cnt_reg  <= 32'h0;
				tick_reg <= 1'b1;
			end else begin
				cnt_reg  <= cnt_reg + 32'h1;
				tick_reg <= 1'b0;
			end
		end
	end

	// New command detect per active float slot
	always_comb begin
		for (int s = 0; s < 4; s++)
			acc[s] = ce && tick_reg && !erase && 2'(s) <= nsl_reg &&
			         fmt_reg == scmd_pkg::FMT_FLT && plc_out[s].cmd != last_reg[s];
	end

	// Rotation lists, saved and restored by software
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int s = 0; s < 4; s++)
				rot_len_reg[s] <= 4'h0;
		end else if (ce) begin
			for (int s = 0; s < 4; s++) begin
				if (erase) begin
					rot_len_reg[s] <= 4'h0;
				end else if (reg_wr && reg_addr[7:4] == scmd_pkg::A_ROT_HI &&
				             reg_addr[3:2] == 2'(s)) begin
					rot_len_reg[s] <= (reg_wdata[21:18] > scmd_pkg::ROT_MAX)
					                  ? scmd_pkg::ROT_MAX : reg_wdata[21:18];
					for (int i = 0; i < 9; i++)
						rot_reg[s][i] <= reg_wdata[2*i +: 2];
				end else if (acc[s] && plc_out[s].cmd == scmd_pkg::OP_CLR) begin
					rot_len_reg[s] <= 4'h0;
				end else if (acc[s] && plc_out[s].cmd[15:4] == scmd_pkg::OP_ADD &&
				             is_rt(plc_out[s].cmd[1:0]) &&
				             rot_len_reg[s] < scmd_pkg::ROT_MAX) begin
					rot_reg[s][rot_len_reg[s]] <= plc_out[s].cmd[1:0];
					rot_len_reg[s] <= rot_len_reg[s] + 4'h1;
				end
			end
		end
	end

	function automatic logic [3:0] nxt(input logic [3:0] p, input logic [3:0] n);
		nxt = (n == 4'h0 || p + 4'h1 >= n) ? 4'h0 : p + 4'h1;
	endfunction : nxt

	function automatic logic [1:0] ent(input int s, input logic [3:0] p);
		ent = (rot_len_reg[s] == 4'h0) ? scmd_pkg::Q_GROSS : rot_reg[s][p];
	endfunction : ent

	// Slot command state
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			target_reg <= 32'h0;
			for (int s = 0; s < 4; s++) begin
				last_reg[s] <= 16'h0;
				ack_reg[s]  <= 2'h0;
				ind_reg[s]  <= scmd_pkg::Q_GROSS;
				mode_reg[s] <= scmd_pkg::M_IDLE;
				val_reg[s]  <= 32'h0;
				pos_reg[s]  <= 4'h0;
			end
		end else if (ce) begin
			for (int s = 0; s < 4; s++) begin
				if (erase) begin
					ack_reg[s]  <= 2'h0;
					mode_reg[s] <= scmd_pkg::M_IDLE;
					pos_reg[s]  <= 4'h0;
				end else if (acc[s]) begin
					last_reg[s] <= plc_out[s].cmd;
					ack_reg[s]  <= (ack_reg[s] == 2'h3) ? 2'h1 : ack_reg[s] + 2'h1;
					if (plc_out[s].cmd == scmd_pkg::OP_NEXT1 ||
					    plc_out[s].cmd == scmd_pkg::OP_NEXT2) begin
						pos_reg[s]  <= nxt(pos_reg[s], rot_len_reg[s]);
						ind_reg[s]  <= scmd_pkg::scmd_qty_t'(ent(s, nxt(pos_reg[s], rot_len_reg[s])));
						val_reg[s]  <= qval(ent(s, nxt(pos_reg[s], rot_len_reg[s])));
						mode_reg[s] <= scmd_pkg::M_MAN;
					end else if (plc_out[s].cmd == scmd_pkg::OP_AUTO) begin
						mode_reg[s] <= scmd_pkg::M_AUTO;
					end else if (plc_out[s].cmd[15:4] == scmd_pkg::OP_RPT) begin
						ind_reg[s]  <= scmd_pkg::scmd_qty_t'(plc_out[s].cmd[1:0]);
						val_reg[s]  <= qval(plc_out[s].cmd[1:0]);
						mode_reg[s] <= is_rt(plc_out[s].cmd[1:0]) ? scmd_pkg::M_RT
						                                          : scmd_pkg::M_STAT;
					end else if (plc_out[s].cmd[15:4] == scmd_pkg::OP_LDT) begin
						target_reg  <= plc_out[s].val;
						ind_reg[s]  <= scmd_pkg::Q_TARGET;
						val_reg[s]  <= plc_out[s].val;
						mode_reg[s] <= scmd_pkg::M_STAT;
					end
				end else if (tick_reg) begin
					case (mode_reg[s])
						scmd_pkg::M_RT, scmd_pkg::M_MAN:
							val_reg[s] <= qval(ind_reg[s]);
						scmd_pkg::M_AUTO: begin
							pos_reg[s] <= nxt(pos_reg[s], rot_len_reg[s]);
							ind_reg[s] <= scmd_pkg::scmd_qty_t'(ent(s, nxt(pos_reg[s], rot_len_reg[s])));
							val_reg[s] <= qval(ent(s, nxt(pos_reg[s], rot_len_reg[s])));
						end
						default: ;
					endcase
				end
			end
		end
	end

	// Discrete I/O on the update tick
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			disc_in_reg  <= 4'h0;
			disc_out_reg <= 4'h0;
		end else if (ce && tick_reg) begin
			disc_in_reg  <= disc_in;
			disc_out_reg <= plc_dout & dmask_reg;
		end
	end

	// Slot input words, rebuilt one cycle after the tick
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			integ_reg  <= 4'h0;
			plc_in_reg <= '0;
		end else if (ce && tick_d_reg) begin
			for (int s = 0; s < 4; s++) begin
				plc_in_reg[s] <= '0;
				if (2'(s) <= nsl_reg) begin
					case (scmd_pkg::scmd_fmt_t'(fmt_reg))
						scmd_pkg::FMT_FLT: begin
							integ_reg[s] <= ~integ_reg[s];
							plc_in_reg[s].resp[scmd_pkg::RSP_INTEG]         <= ~integ_reg[s];
							plc_in_reg[s].resp[scmd_pkg::RSP_IND_LSB +: 3]  <= {1'b0, ind_reg[s]};
							plc_in_reg[s].resp[scmd_pkg::RSP_ACK_LSB +: 2]  <= ack_reg[s];
							{plc_in_reg[s].val_hi, plc_in_reg[s].val_lo}  <= ord32(val_reg[s], ord_reg);
							plc_in_reg[s].stat <= {~integ_reg[s], 11'h000, disc_in_reg};
						end
						scmd_pkg::FMT_INT, scmd_pkg::FMT_DIV: begin
							plc_in_reg[s].resp <= ord32({16'h0000,
								sat16(fmt_reg == scmd_pkg::FMT_INT ? wt_int : wt_div)},
								ord_reg == scmd_pkg::ORD_BYTE ? ord_reg : scmd_pkg::ORD_STD)
								>> 0 == 32'h0 ? 16'h0000 :
								((ord_reg == scmd_pkg::ORD_BYTE || ord_reg == scmd_pkg::ORD_DWORD)
								? {sat16(fmt_reg == scmd_pkg::FMT_INT ? wt_int : wt_div)} << 8 |
								  sat16(fmt_reg == scmd_pkg::FMT_INT ? wt_int : wt_div) >> 8
								: sat16(fmt_reg == scmd_pkg::FMT_INT ? wt_int : wt_div));
							plc_in_reg[s].val_hi <= {12'h000, disc_in_reg};
						end
						default: ;
					endcase
				end
			end
		end
	end

	// Register read port
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_reg <= 32'h0;
		end else if (ce) begin
			rdata_reg <= 32'h0;
			if (reg_rd) begin
				if (reg_addr[7:4] == scmd_pkg::A_ROT_HI) begin
					rdata_reg[21:18] <= rot_len_reg[reg_addr[3:2]];
					for (int i = 0; i < 9; i++)
						rdata_reg[2*i +: 2] <= rot_reg[reg_addr[3:2]][i];
				end else begin
					case (reg_addr)
						scmd_pkg::A_CFG:   rdata_reg[5:0] <= {nsl_reg, ord_reg, fmt_reg};
						scmd_pkg::A_TICK:  rdata_reg      <= per_reg;
						scmd_pkg::A_DMASK: rdata_reg[3:0] <= dmask_reg;
						scmd_pkg::A_STAT:  rdata_reg[15:0] <= {ack_reg[3], ack_reg[2],
							ack_reg[1], ack_reg[0], disc_in_reg, disc_out_reg};
						scmd_pkg::A_LED:   rdata_reg[3:0] <= led_err_reg;
						default: ;
					endcase
				end
			end
		end
	end

	// Status indicators
	assign step = step_cnt_reg >= 32'(LED_STEP_CYC) - 32'h1;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			step_cnt_reg <= 32'h0;
			blink_reg    <= 3'h0;
			nph_reg      <= 5'h0;
			red_reg      <= 1'b0;
			net_reg      <= 1'b0;
			act_reg      <= 1'b0;
		end else if (ce) begin
			step_cnt_reg <= step ? 32'h0 : step_cnt_reg + 32'h1;
			if (step) begin
				blink_reg <= blink_reg + 3'h1;
				nph_reg   <= (nph_reg >= {1'b0, net_conn, 1'b0} + 5'h2) ? 5'h0 : nph_reg + 5'h1;
			end
			if (led_err_reg[3])      red_reg <= 1'b1;
			else if (led_err_reg[2]) red_reg <= blink_reg[0];
			else if (led_err_reg[1]) red_reg <= blink_reg[1];
			else if (led_err_reg[0]) red_reg <= blink_reg[2];
			else                     red_reg <= 1'b0;
			net_reg <= nph_reg < {1'b0, net_conn, 1'b0} && !nph_reg[0];
			act_reg <= pkt_evt ? 1'b1 : (step ? 1'b0 : act_reg);
		end
	end

	assign reg_rdata   = rdata_reg;
	assign plc_in      = plc_in_reg;
	assign disc_out    = disc_out_reg;
	assign led_mod_red = red_reg;
	assign led_net     = net_reg;
	assign led_act     = act_reg;

	chk_no_recmd: assert property (@(posedge mclk) disable iff (!rst_b)
		(ce && tick_reg && !erase && plc_out[0].cmd == last_reg[0]) |=> $stable(ack_reg[0]))
		else $error("repeat command re-acknowledged");
	chk_ack_new: assert property (@(posedge mclk) disable iff (!rst_b)
		acc[0] |=> ack_reg[0] != $past(ack_reg[0]) && ack_reg[0] != 2'h0)
		else $error("acknowledge did not change");
	chk_ind_rpt: assert property (@(posedge mclk) disable iff (!rst_b)
		(acc[0] && plc_out[0].cmd[15:4] == scmd_pkg::OP_RPT)
		|=> ind_reg[0] == $past(plc_out[0].cmd[1:0]) ##1 (!$past(ce) ||
		    plc_in[0].resp[12:10] == {1'b0, $past(plc_out[0].cmd[1:0], 2)}))
		else $error("indicator wrong");
	chk_static_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		(mode_reg[0] == scmd_pkg::M_STAT && !acc[0]) |=> $stable(val_reg[0]))
		else $error("static value changed");
	chk_rot_limit: assert property (@(posedge mclk) disable iff (!rst_b)
		rot_len_reg[0] <= scmd_pkg::ROT_MAX)
		else $error("rotation too long");
	chk_auto_adv: assert property (@(posedge mclk) disable iff (!rst_b)
		(mode_reg[0] == scmd_pkg::M_AUTO && ce && tick_reg && !acc[0] && !erase &&
		 rot_len_reg[0] > 4'h1) |=> pos_reg[0] != $past(pos_reg[0]))
		else $error("rotation did not advance");
	chk_integ_eq: assert property (@(posedge mclk) disable iff (!rst_b)
		(ce && tick_d_reg && fmt_reg == scmd_pkg::FMT_FLT) |=>
		plc_in[0].resp[scmd_pkg::RSP_INTEG] == plc_in[0].stat[scmd_pkg::STAT_INTEG])
		else $error("integrity bits differ");
	chk_dout_tick: assert property (@(posedge mclk) disable iff (!rst_b)
		$changed(disc_out) |-> $past(tick_reg && ce))
		else $error("discrete output off tick");
	chk_tick_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
		(ce && tick_reg && per_reg > 32'h1) |=> !tick_reg)
		else $error("tick wider than one cycle");
	cov_rpt: cover property (@(posedge mclk) disable iff (!rst_b)
		acc[0] && plc_out[0].cmd[15:4] == scmd_pkg::OP_RPT);
	cov_auto: cover property (@(posedge mclk) disable iff (!rst_b)
		mode_reg[0] == scmd_pkg::M_AUTO && tick_reg && rot_len_reg[0] > 4'h1);
	cov_erase: cover property (@(posedge mclk) disable iff (!rst_b) erase);
endmodule : scmd_slot_cmd

// ### dv/scmd_plc_model.sv
// Purpose: Controller side of the slot link, driving command and value words.
// Assumes: Float format; one command in flight per slot.
// Notes:   The bench calls the tasks; words change only after a clock edge.
`timescale 1ns/10ps
module scmd_plc_model (
	input  logic                       mclk,
	output scmd_pkg::scmd_cmd_t [3:0]  plc_out,
	input  scmd_pkg::scmd_resp_t [3:0] plc_in
);
	initial plc_out = '0;

	// Operand first, then command, then wait for the acknowledge to move
	task send(input int s, input logic [15:0] cmd, input logic [31:0] val, output logic ok);
		logic [1:0] ack0;
		int         n;
		ack0 = plc_in[s].resp[9:8];
		ok = 1'b0;
		@(posedge mclk);
		plc_out[s].val <= val;
		@(posedge mclk);
		plc_out[s].cmd <= cmd;
		for (n = 0; n < 80 && ok !== 1'b1; n++) begin
			@(posedge mclk);
			#1 ok = (plc_in[s].resp[9:8] !== ack0);
		end
	endtask : send

	function automatic logic valid(input int s);
		return plc_in[s].resp[15] === plc_in[s].stat[15];
	endfunction : valid
endmodule : scmd_plc_model

// ### dv/tb.sv
// Purpose: Self-checking bench of the slot command block.
// Assumes: Shortened tick and LED step periods.
// Notes:   One task per scenario.
`timescale 1ns/10ps
module tb;
	localparam int U = 20;
	logic                       mclk = 1'b0;
	logic                       rst_b = 1'b0;
	logic                       ce = 1'b1;
	logic [7:0]                 reg_addr = 8'h00;
	logic [31:0]                reg_wdata = 32'h0;
	logic                       reg_wr = 1'b0;
	logic                       reg_rd = 1'b0;
	logic [31:0]                reg_rdata;
	scmd_pkg::scmd_cmd_t [3:0]  plc_out;
	scmd_pkg::scmd_resp_t [3:0] plc_in;
	logic [31:0]                gross_f = 32'h41200000;
	logic [31:0]                net_f = 32'h3F800000;
	logic [31:0]                tare_f = 32'h40A00000;
	logic [31:0]                wt_int = 32'h0;
	logic [31:0]                wt_div = 32'h0;
	logic [3:0]                 plc_dout = 4'h0;
	logic [3:0]                 disc_in = 4'h0;
	logic [3:0]                 disc_out;
	logic                       pkt_evt = 1'b0;
	logic                       led_mod_red;
	logic                       led_net;
	logic                       led_act;
	int                         miscompares = 0;
	int                         samples_checked = 0;
	int                         cyc = 0;
	logic [31:0]                d;
	logic [2:0]                 i1;

	always #4 mclk = ~mclk;

	scmd_slot_cmd #(.UPD_CYC(U), .LED_STEP_CYC(8)) u_scmd_slot_cmd (
		.mclk(mclk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .plc_out(plc_out),
		.plc_in(plc_in), .gross_f(gross_f), .net_f(net_f), .tare_f(tare_f),
		.wt_int(wt_int), .wt_div(wt_div), .plc_dout(plc_dout), .disc_in(disc_in),
		.disc_out(disc_out), .net_conn(3'h2), .pkt_evt(pkt_evt),
		.led_mod_red(led_mod_red), .led_net(led_net), .led_act(led_act));

	scmd_plc_model u_scmd_plc_model (.mclk(mclk), .plc_out(plc_out), .plc_in(plc_in));

	task print_verdict;
		if (miscompares == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			miscompares++;
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	task send(input int s, input logic [15:0] c, input logic [31:0] v);
		logic ok;
		u_scmd_plc_model.send(s, c, v, ok);
		chk({31'h0, ok}, 32'h1);
	endtask : send

	task wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : wt

	task t_reset;
		chk(plc_in[0].resp, 32'h0);
		rd(scmd_pkg::A_CFG);
		chk(d, 32'h00000008);
		rd(8'h3C);
		chk(d, 32'h0);
		wr(scmd_pkg::A_CFG, 32'h0000000A);
		wt(2 * U);
		chk(plc_in[1][63:32] | plc_in[1][31:0], 32'h0);
		wr(scmd_pkg::A_CFG, 32'h0000003A);
		rd(scmd_pkg::A_CFG);
		chk(d, 32'h0000003A);
	endtask : t_reset

	task t_realtime;
		logic b;
		send(0, 16'h0020, 32'h0);
		chk(plc_in[0].resp[9:8], 32'h1);
		chk(plc_in[0].resp[12:10], 32'(scmd_pkg::Q_GROSS));
		chk({plc_in[0].val_hi, plc_in[0].val_lo}, {gross_f[15:0], gross_f[31:16]});
		chk(u_scmd_plc_model.valid(0), 32'h1);
		if (u_scmd_plc_model.valid(0) !== 1'b1)
			send(0, 16'h0021, 32'h0);
		b = plc_in[0].resp[15];
		@(posedge mclk);
		gross_f <= 32'hC2C81234;
		wt(U - 1);
		chk(plc_in[0].resp[15], {31'h0, ~b});
		wt(U);
		chk({plc_in[0].val_hi, plc_in[0].val_lo}, 32'h1234C2C8);
		b = plc_in[0].resp[15];
		@(posedge mclk);
		ce <= 1'b0;
		wt(3 * U);
		chk(plc_in[0].resp[15], {31'h0, b});
		ce <= 1'b1;
	endtask : t_realtime

	task t_static;
		send(0, 16'h0022, 32'h0);
		chk(plc_in[0].resp[12:10], 32'(scmd_pkg::Q_TARE));
		@(posedge mclk);
		tare_f <= 32'h3F000000;
		wt(3 * U);
		chk({plc_in[0].val_hi, plc_in[0].val_lo}, 32'h000040A0);
		chk(plc_in[0].resp[9:8], 32'h2);
		send(1, 16'h0033, 32'h42480000);
		send(1, 16'h0023, 32'h0);
		chk({plc_in[1].val_hi, plc_in[1].val_lo}, 32'h00004248);
	endtask : t_static

	task t_rotation;
		send(0, 16'h0004, 32'h0);
		send(0, 16'h0001, 32'h0);
		chk(plc_in[0].resp[12:10], 32'(scmd_pkg::Q_GROSS));
		for (int i = 0; i < 10; i++)
			send(0, 16'h0010 + 16'(i % 2), 32'h0);
		rd(8'h10);
		chk(d[21:18], 32'h9);
		send(0, 16'h0004, 32'h0);
		send(0, 16'h0010, 32'h0);
		send(0, 16'h0011, 32'h0);
		send(0, 16'h0002, 32'h0);
		chk(plc_in[0].resp[12:10], 32'(scmd_pkg::Q_NET));
		chk({plc_in[0].val_hi, plc_in[0].val_lo}, {net_f[15:0], net_f[31:16]});
		i1 = plc_in[0].resp[12:10];
		send(0, 16'h0001, 32'h0);
		chk(32'(i1 != plc_in[0].resp[12:10]), 32'h1);
		send(0, 16'h0003, 32'h0);
		i1 = plc_in[0].resp[12:10];
		wt(U);
		chk(32'(i1 != plc_in[0].resp[12:10]), 32'h1);
	endtask : t_rotation

	task t_discrete;
		logic b;
		wr(scmd_pkg::A_DMASK, 32'h5);
		plc_dout <= 4'hF;
		disc_in <= 4'hA;
		wt(2 * U);
		chk(disc_out, 32'h5);
		rd(scmd_pkg::A_STAT);
		chk(d[7:0], 32'hA5);
		b = plc_in[0].stat[15];
		for (int n = 0; n < 2 * U && plc_in[0].stat[15] === b; n++)
			wt(1);
		plc_dout <= 4'h0;
		wt(U / 2);
		chk(disc_out, 32'h5);
		wt(U);
		chk(disc_out, 32'h0);
	endtask : t_discrete

	task t_format;
		wr(scmd_pkg::A_CFG, 32'h00000008);
		rd(scmd_pkg::A_STAT);
		chk(d[15:8], 32'h0);
		wt_int <= 32'h00009C40;
		wt(2 * U);
		chk(plc_in[0].resp, 32'h7FFF);
		wt_int <= 32'hFFFF63C0;
		wt(2 * U);
		chk(plc_in[0].resp, 32'h8001);
		wr(scmd_pkg::A_CFG, 32'h00000004);
		wt(2 * U);
		chk(plc_in[0].resp, 32'h0180);
		wt_div <= 32'h00001234;
		wr(scmd_pkg::A_CFG, 32'h00000005);
		wt(2 * U);
		chk(plc_in[0].resp, 32'h3412);
	endtask : t_format

	task t_leds;
		int   n;
		logic p;
		wr(scmd_pkg::A_LED, 32'h8);
		n = 0;
		repeat (64) begin
			wt(1);
			n += int'(led_mod_red === 1'b1);
		end
		chk(n, 32'd64);
		for (int i = 0; i < 3; i++) begin
			wr(scmd_pkg::A_LED, 32'h1 << i);
			n = 0;
			p = led_mod_red;
			repeat (256) begin
				wt(1);
				n += int'(led_mod_red !== p);
				p = led_mod_red;
			end
			if (n == (8 << i) - 1 || n == (8 << i) + 1)
				n = 8 << i;
			chk(n, 32'd8 << i);
		end
		n = 0;
		p = led_net;
		repeat (112) begin
			wt(1);
			n += int'(led_net === 1'b1 && p === 1'b0);
			p = led_net;
		end
		chk(n, 32'd4);
		@(posedge mclk);
		pkt_evt <= 1'b1;
		@(posedge mclk);
		pkt_evt <= 1'b0;
		#1;
		chk(led_act, 32'h1);
		wt(8);
		chk(led_act, 32'h0);
	endtask : t_leds

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			print_verdict();
		end
	end

	initial begin
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_realtime();
		t_static();
		t_rotation();
		t_discrete();
		t_format();
		t_leds();
		print_verdict();
	end
endmodule : tb
